// ### rtl/pebf_pkg.sv
`default_nettype none

package pebf_pkg;

    // ************************************************************
    // Datapath widths
    // ************************************************************
    localparam int unsigned PEBF_W      = 32;     // Register word width
    localparam int unsigned PEBF_HALF_W = 16;     // Halfword width
    localparam int unsigned PEBF_BYTE_W = 8;      // Byte width
    localparam int unsigned PEBF_SHAMT_W = 5;     // Immediate shift field width
    localparam int unsigned PEBF_ROT_W  = 2;      // Rotate select width
    localparam int unsigned PEBF_LSB_W  = 5;      // Field low position width
    localparam int unsigned PEBF_FWID_W = 6;      // Field width field, 1..32
    localparam int unsigned PEBF_END_W  = 7;      // Field end position width

    typedef logic [PEBF_W-1:0] pebf_word_t;       // One register operand

    // ************************************************************
    // Immediate encodings
    // ************************************************************
    localparam logic [PEBF_SHAMT_W-1:0] PEBF_ASR_FULL_CODE = 5'h00; // Means shift of 32
    localparam logic [PEBF_ROT_W-1:0]   PEBF_ROT_0  = 2'h0;         // No rotation
    localparam logic [PEBF_ROT_W-1:0]   PEBF_ROT_8  = 2'h1;         // Rotate right 8
    localparam logic [PEBF_ROT_W-1:0]   PEBF_ROT_16 = 2'h2;         // Rotate right 16
    localparam logic [PEBF_ROT_W-1:0]   PEBF_ROT_24 = 2'h3;         // Rotate right 24

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam pebf_word_t PEBF_RESULT_RST = 32'h0;   // Write-back word
    localparam logic       PEBF_VALID_RST  = 1'h0;    // Write-back strobe
    localparam logic       PEBF_FLAGS_RST  = 1'h0;    // Flag write strobe

    // ************************************************************
    // Operation select, one-hot
    // ************************************************************
    typedef enum logic [15:0] {
        OP_PACK_LOW_THEN_HIGH        = 16'h0001,
        OP_PACK_HIGH_THEN_LOW        = 16'h0002,
        OP_SIGNED_BYTE_WIDEN         = 16'h0004,
        OP_UNSIGNED_BYTE_WIDEN       = 16'h0008,
        OP_SIGNED_HALF_WIDEN         = 16'h0010,
        OP_UNSIGNED_HALF_WIDEN       = 16'h0020,
        OP_DUAL_SIGNED_BYTE_WIDEN    = 16'h0040,
        OP_DUAL_UNSIGNED_BYTE_WIDEN  = 16'h0080,
        OP_SIGNED_BYTE_WIDEN_ADD     = 16'h0100,
        OP_UNSIGNED_BYTE_WIDEN_ADD   = 16'h0200,
        OP_SIGNED_HALF_WIDEN_ADD     = 16'h0400,
        OP_UNSIGNED_HALF_WIDEN_ADD   = 16'h0800,
        OP_DUAL_SIGNED_BYTE_WIDEN_ADD   = 16'h1000,
        OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD = 16'h2000,
        OP_FIELD_CLEAR               = 16'h4000,
        OP_FIELD_INSERT              = 16'h8000
    } pebf_op_e;

endpackage

`default_nettype wire

// ### rtl/pebf_dp_if.sv
`default_nettype none

// ************************************************************
// Links the core to its widen and field helpers
// ************************************************************
interface pebf_dp_if;
    import pebf_pkg::*;

    pebf_word_t              wid_src;      // Word to rotate and widen
    logic [PEBF_ROT_W-1:0]   wid_rot;      // Rotate select
    logic                    wid_signed;   // Sign fill when high
    pebf_word_t              wid_byte;     // Byte widened to word
    pebf_word_t              wid_half;     // Half widened to word
    pebf_word_t              wid_dual;     // Two bytes widened to halves

    pebf_word_t              fld_dest;     // Old destination value
    pebf_word_t              fld_src;      // Insert source
    logic [PEBF_LSB_W-1:0]   fld_lsb;      // Field low position
    logic [PEBF_FWID_W-1:0]  fld_width;    // Field width
    logic                    fld_insert;   // Insert when high, clear when low
    pebf_word_t              fld_result;   // Updated destination

    modport widen_mp (input wid_src, wid_rot, wid_signed,
                      output wid_byte, wid_half, wid_dual);
    modport field_mp (input fld_dest, fld_src, fld_lsb, fld_width, fld_insert,
                      output fld_result);
    modport core_mp  (output wid_src, wid_rot, wid_signed,
                      fld_dest, fld_src, fld_lsb, fld_width, fld_insert,
                      input wid_byte, wid_half, wid_dual, fld_result);
endinterface

`default_nettype wire

// ### rtl/pebf_widen.sv
`default_nettype none

// ************************************************************
// Rotate then widen bytes and halves
// ************************************************************
module pebf_widen (
    pebf_dp_if.widen_mp dp      // Widen side of the datapath link
);
    import pebf_pkg::*;

    pebf_word_t rot_w;          // Source after rotation
    logic       sb_lo;          // Fill bit from bit 7
    logic       sb_half;        // Fill bit from bit 15
    logic       sb_hi;          // Fill bit from bit 23

    // Rotation by whole bytes only
    assign rot_w = (dp.wid_rot == PEBF_ROT_8)  ? {dp.wid_src[7:0],  dp.wid_src[31:8]}  :
                   (dp.wid_rot == PEBF_ROT_16) ? {dp.wid_src[15:0], dp.wid_src[31:16]} :
                   (dp.wid_rot == PEBF_ROT_24) ? {dp.wid_src[23:0], dp.wid_src[31:24]} :
                                                 dp.wid_src;

    // Fill bits are zero for the unsigned forms
    assign sb_lo   = dp.wid_signed & rot_w[7];
    assign sb_half = dp.wid_signed & rot_w[15];
    assign sb_hi   = dp.wid_signed & rot_w[23];

    // Byte to word
    assign dp.wid_byte = {{(PEBF_W-PEBF_BYTE_W){sb_lo}}, rot_w[7:0]};
    // Half to word
    assign dp.wid_half = {{(PEBF_W-PEBF_HALF_W){sb_half}}, rot_w[15:0]};
    // Bytes 0 and 2 each to a half
    assign dp.wid_dual = {{(PEBF_HALF_W-PEBF_BYTE_W){sb_hi}}, rot_w[23:16],
                          {(PEBF_HALF_W-PEBF_BYTE_W){sb_lo}}, rot_w[7:0]};
endmodule

`default_nettype wire

// ### rtl/pebf_field.sv
`default_nettype none

// ************************************************************
// Clear or insert a run of bits
// ************************************************************
module pebf_field (
    pebf_dp_if.field_mp dp      // Field side of the datapath link
);
    import pebf_pkg::*;

    logic [PEBF_END_W-1:0] fld_end;   // First bit past the field
    pebf_word_t            src_sh;    // Source moved up to the field
    pebf_word_t            in_fld;    // Per-bit field membership
    pebf_word_t            res_w;     // Per-bit result

    // End stays in range only if the issuer keeps lsb plus width within 32
    assign fld_end = PEBF_END_W'(dp.fld_lsb) + PEBF_END_W'(dp.fld_width);
    assign src_sh  = dp.fld_src << dp.fld_lsb;

    // One cell per destination bit
    for (genvar i = 0; i < PEBF_W; i++) begin : g_bit
        assign in_fld[i] = (PEBF_END_W'(i) >= PEBF_END_W'(dp.fld_lsb)) &&
                           (PEBF_END_W'(i) < fld_end);
        // Outside the field the destination passes unchanged
        assign res_w[i]  = in_fld[i] ? (dp.fld_insert & src_sh[i])
                                     : dp.fld_dest[i];
    end

    assign dp.fld_result = res_w;
endmodule

`default_nettype wire

// ### rtl/pebf_unit.sv
// How it works
// - Low-high pack shifts second left 0..31
// - Low half first, high half shifted second
// - High-low pack arithmetic right, code 0 means 32
// - High half first, low half shifted second
// - No operation here ever writes condition flags
// - Widen operations rotate source by 0/8/16/24
// - Byte widen takes bits 7:0, fills
// - Half widen takes bits 15:0, fills
// - Dual widen: bytes 0,2 into halves
// - Widen-add adds widened value to first word
// - Dual widen-add adds halves with no carry
// - Field clear zeroes width bits from lsb
// - Field insert copies low source bits in
`default_nettype none

module pebf_unit (
    input  wire logic                              clk_i,             // Core clock
    input  wire logic                              srst_i,            // Sync reset, high
    input  wire logic                              ce_i,              // Clock enable
    input  wire logic                              issue_i,           // Operation issued
    input  wire pebf_pkg::pebf_op_e                op_i,              // Operation select
    input  wire pebf_pkg::pebf_word_t              first_operand_i,   // First operand
    input  wire pebf_pkg::pebf_word_t              second_operand_i,  // Second operand
    input  wire pebf_pkg::pebf_word_t              dest_old_i,        // Old destination
    input  wire logic [pebf_pkg::PEBF_SHAMT_W-1:0] shift_amount_i,    // Pack shift amount
    input  wire logic [pebf_pkg::PEBF_ROT_W-1:0]   rotate_right_amount_i, // Rotate select
    input  wire logic [pebf_pkg::PEBF_LSB_W-1:0]   field_lsb_i,       // Field low position
    input  wire logic [pebf_pkg::PEBF_FWID_W-1:0]  field_width_i,     // Field width
    output logic       [pebf_pkg::PEBF_W-1:0]      result_o,          // Write-back word
    output logic                                   result_valid_o,    // Write-back strobe
    output logic                                   flags_we_o         // Flag write, always low
);
    import pebf_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    pebf_dp_if  dp ();                  // Link to helper modules

    pebf_word_t result_r;               // Registered result
    pebf_word_t result_nxt;             // Next result
    logic       valid_r;                // Registered strobe
    logic       valid_nxt;              // Next strobe
    logic       flags_we_r;             // Registered flag strobe
    logic       flags_we_nxt;           // Next flag strobe

    // Operation class decode
    logic       is_pack_lh;             // Low then high pack
    logic       is_pack_hl;             // High then low pack
    logic       is_byte;                // Byte widen, either sign
    logic       is_half;                // Half widen, either sign
    logic       is_dual;                // Dual byte widen, either sign
    logic       is_byte_add;            // Byte widen add
    logic       is_half_add;            // Half widen add
    logic       is_dual_add;            // Dual byte widen add
    logic       is_clear;               // Field clear
    logic       is_insert;              // Field insert
    logic       is_signed;              // Any signed widen form
    logic       op_legal;               // Code names a real operation

    // Pack datapath
    pebf_word_t lsl_w;                  // Second operand shifted left
    pebf_word_t asr_w;                  // Second operand shifted right
    pebf_word_t pack_lh_w;              // Low then high result
    pebf_word_t pack_hl_w;              // High then low result

    // Widen-add datapath
    pebf_word_t byte_add_w;             // First plus widened byte
    pebf_word_t half_add_w;             // First plus widened half
    logic [PEBF_HALF_W-1:0] dual_lo_w;  // Low half sum
    logic [PEBF_HALF_W-1:0] dual_hi_w;  // High half sum
    pebf_word_t dual_add_w;             // Both half sums

    // ************************************************************
    // Operation decode
    // ************************************************************
    // Each widen class merges its signed and unsigned codes
    assign is_pack_lh  = (op_i == OP_PACK_LOW_THEN_HIGH);
    assign is_pack_hl  = (op_i == OP_PACK_HIGH_THEN_LOW);
    assign is_byte     = (op_i == OP_SIGNED_BYTE_WIDEN) ||
                         (op_i == OP_UNSIGNED_BYTE_WIDEN);
    assign is_half     = (op_i == OP_SIGNED_HALF_WIDEN) ||
                         (op_i == OP_UNSIGNED_HALF_WIDEN);
    assign is_dual     = (op_i == OP_DUAL_SIGNED_BYTE_WIDEN) ||
                         (op_i == OP_DUAL_UNSIGNED_BYTE_WIDEN);
    assign is_byte_add = (op_i == OP_SIGNED_BYTE_WIDEN_ADD) ||
                         (op_i == OP_UNSIGNED_BYTE_WIDEN_ADD);
    assign is_half_add = (op_i == OP_SIGNED_HALF_WIDEN_ADD) ||
                         (op_i == OP_UNSIGNED_HALF_WIDEN_ADD);
    assign is_dual_add = (op_i == OP_DUAL_SIGNED_BYTE_WIDEN_ADD) ||
                         (op_i == OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD);
    assign is_clear    = (op_i == OP_FIELD_CLEAR);
    assign is_insert   = (op_i == OP_FIELD_INSERT);

    // Sign fill selects replicate the top bit of the taken part
    assign is_signed   = (op_i == OP_SIGNED_BYTE_WIDEN)          ||
                         (op_i == OP_SIGNED_HALF_WIDEN)          ||
                         (op_i == OP_DUAL_SIGNED_BYTE_WIDEN)     ||
                         (op_i == OP_SIGNED_BYTE_WIDEN_ADD)      ||
                         (op_i == OP_SIGNED_HALF_WIDEN_ADD)      ||
                         (op_i == OP_DUAL_SIGNED_BYTE_WIDEN_ADD);

    // A code that is not one-hot or is zero is not an operation
    assign op_legal    = is_pack_lh  | is_pack_hl  | is_byte     | is_half  |
                         is_dual     | is_byte_add | is_half_add | is_dual_add |
                         is_clear    | is_insert;

    // ************************************************************
    // Pack halfword
    // ************************************************************
    // Left shift: an amount of zero leaves the operand as it is
    assign lsl_w = second_operand_i << shift_amount_i;

    // Arithmetic right shift: code zero stands for 32, all sign bits
    assign asr_w = (shift_amount_i == PEBF_ASR_FULL_CODE)
                 ? {PEBF_W{second_operand_i[PEBF_W-1]}}
                 : pebf_word_t'($signed(second_operand_i) >>> shift_amount_i);

    // Low half from first operand, high half from shifted second
    assign pack_lh_w = {lsl_w[PEBF_W-1:PEBF_HALF_W],
                        first_operand_i[PEBF_HALF_W-1:0]};

    // High half from first operand, low half from shifted second
    assign pack_hl_w = {first_operand_i[PEBF_W-1:PEBF_HALF_W],
                        asr_w[PEBF_HALF_W-1:0]};

    // ************************************************************
    // Rotate and widen helper
    // ************************************************************
    // The second operand is the source of every widen form
    assign dp.wid_src    = second_operand_i;
    assign dp.wid_rot    = rotate_right_amount_i;
    assign dp.wid_signed = is_signed;

    pebf_widen u_widen (
        .dp (dp.widen_mp)
    );

    // ************************************************************
    // Widen and add
    // ************************************************************
    // Full-word sums wrap modulo two to the 32
    assign byte_add_w = first_operand_i + dp.wid_byte;
    assign half_add_w = first_operand_i + dp.wid_half;

    // Half sums are separate so no carry crosses bit 15
    assign dual_lo_w  = first_operand_i[PEBF_HALF_W-1:0] +
                        dp.wid_dual[PEBF_HALF_W-1:0];
    assign dual_hi_w  = first_operand_i[PEBF_W-1:PEBF_HALF_W] +
                        dp.wid_dual[PEBF_W-1:PEBF_HALF_W];
    assign dual_add_w = {dual_hi_w, dual_lo_w};

    // ************************************************************
    // Bit field helper
    // ************************************************************
    // Destination bits outside the field come from its old value
    assign dp.fld_dest   = dest_old_i;
    assign dp.fld_src    = first_operand_i;
    assign dp.fld_lsb    = field_lsb_i;
    assign dp.fld_width  = field_width_i;
    assign dp.fld_insert = is_insert;

    pebf_field u_field (
        .dp (dp.field_mp)
    );

    // ************************************************************
    // Result select
    // ************************************************************
    // All paths are combinational, picked in the issue cycle
    assign result_nxt = is_pack_lh  ? pack_lh_w     :
                        is_pack_hl  ? pack_hl_w     :
                        is_byte     ? dp.wid_byte   :
                        is_half     ? dp.wid_half   :
                        is_dual     ? dp.wid_dual   :
                        is_byte_add ? byte_add_w    :
                        is_half_add ? half_add_w    :
                        is_dual_add ? dual_add_w    :
                        (is_clear | is_insert) ? dp.fld_result :
                        PEBF_RESULT_RST;

    // Strobe only for a real operation issued this cycle
    assign valid_nxt    = issue_i & op_legal;

    // Flags are never written by this unit
    assign flags_we_nxt = PEBF_FLAGS_RST;

    // ************************************************************
    // Write-back register
    // ************************************************************
    // Result is held until the next legal enabled issue; strobe lasts one enabled cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            result_r   <= PEBF_RESULT_RST;
            valid_r    <= PEBF_VALID_RST;
            flags_we_r <= PEBF_FLAGS_RST;
        end else if (ce_i) begin
            if (valid_nxt) begin
                result_r <= result_nxt;
            end
            valid_r    <= valid_nxt;
            flags_we_r <= flags_we_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign result_o       = result_r;
    assign result_valid_o = valid_r;
    assign flags_we_o     = flags_we_r;

endmodule

`default_nettype wire

// ### verification/pebf_unit_props.sv
`default_nettype none
// ****************
// Result checks
// ****************
module pebf_unit_props
    import pebf_pkg::*;
(
    input wire logic                         clk_i,           // Clock
    input wire logic                         srst_i,          // Reset
    input wire logic                         ce_i,            // Enable
    input wire logic                         issue_i,         // Issue
    input wire pebf_pkg::pebf_op_e           op_i,            // Operation
    input wire pebf_pkg::pebf_word_t         first_operand_i, // First word
    input wire logic [pebf_pkg::PEBF_W-1:0]  result_o,        // Result
    input wire logic                         result_valid_o,  // Strobe
    input wire logic                         flags_we_o       // Flag write
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire logic go;  // Legal issue taken
    assign go = issue_i && ce_i && $onehot(op_i);
    a_flags_never_set: assert property (!flags_we_o)
        else $error("flag write seen");
    a_strobe_after_issue: assert property (go |=> result_valid_o)
        else $error("no strobe after issue");
    a_hold_when_idle: assert property (
        ce_i && !go |=> !result_valid_o && $stable(result_o))
        else $error("result moved without issue");
    a_freeze_no_enable: assert property (
        !ce_i |=> $stable(result_o) && $stable(result_valid_o))
        else $error("outputs moved with enable low");
    a_pack_low_half: assert property (go && op_i == OP_PACK_LOW_THEN_HIGH
        |=> result_o[15:0] == $past(first_operand_i[15:0]))
        else $error("low pack half wrong");
    a_pack_high_half: assert property (go && op_i == OP_PACK_HIGH_THEN_LOW
        |=> result_o[31:16] == $past(first_operand_i[31:16]))
        else $error("high pack half wrong");
    a_byte_zero_fill: assert property (go && op_i == OP_UNSIGNED_BYTE_WIDEN
        |=> result_o[31:8] == 24'h000000)
        else $error("byte fill wrong");
    a_half_sign_fill: assert property (go && op_i == OP_SIGNED_HALF_WIDEN
        |=> result_o[31:16] == {16{result_o[15]}})
        else $error("half sign fill wrong");
    a_dual_zero_fill: assert property (go && op_i == OP_DUAL_UNSIGNED_BYTE_WIDEN
        |=> result_o[15:8] == 8'h00 && result_o[31:24] == 8'h00)
        else $error("dual fill wrong");
    c_field_insert: cover property (go && op_i == OP_FIELD_INSERT);
    c_disabled_issue: cover property (!ce_i && issue_i);
    c_illegal_issue: cover property (issue_i && ce_i && !$onehot(op_i));
endmodule
`default_nettype wire

// ### verification/pebf_issuer.sv
`default_nettype none
// ****************
// Issuing pipeline model
// ****************
module pebf_issuer (
    input  wire logic                   clk_i,    // Clock
    output var  logic                   ce_o,     // Enable
    output var  logic                   issue_o,  // Issue
    output var  pebf_pkg::pebf_op_e     op_o,     // Operation
    output var  pebf_pkg::pebf_word_t   a_o,      // First word
    output var  pebf_pkg::pebf_word_t   b_o,      // Second word
    output var  pebf_pkg::pebf_word_t   d_o,      // Old destination
    output var  logic [4:0]             sh_o,     // Shift amount
    output var  logic [1:0]             rot_o,    // Rotate select
    output var  logic [4:0]             lsb_o,    // Field low bit
    output var  logic [5:0]             w_o       // Field width
);
    import pebf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet values at time zero
    initial begin
        {ce_o, issue_o, a_o, b_o, d_o, sh_o, rot_o, lsb_o, w_o} = '0;
        op_o = OP_FIELD_CLEAR;
    end
    // One issue, held across its sampling edge
    task automatic send(input logic c, pebf_op_e o, pebf_word_t a, b, d,
                        logic [4:0] s, logic [1:0] r, logic [4:0] l, logic [5:0] w);
        @(posedge clk_i);
        {ce_o, issue_o, op_o, a_o, b_o, d_o, sh_o, rot_o} <= {c, 1'b1, o, a, b, d, s, r};
        lsb_o <= l; // Callers keep 0..31
        w_o   <= w; // Callers keep 1..32-lsb
        @(posedge clk_i);
        issue_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verification/pack_extend_bitfield_unit_test.sv
`default_nettype none
module pack_extend_bitfield_unit_test;
    import pebf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, srst_i, ce, iss, rv, fw;  // Clock, reset, handshake
    pebf_op_e op;                          // Operation
    pebf_word_t a, b, d, res, last;        // Words
    logic [4:0] sh, lsb;                   // Shift, field low bit
    logic [1:0] rot;                       // Rotate select
    logic [5:0] w;                         // Field width
    int num_errors = 0;                    // Mismatches
    int tests_run = 0;                     // Comparisons
    pebf_issuer i_pebf_issuer (.clk_i(clk_i), .ce_o(ce), .issue_o(iss), .op_o(op), .a_o(a),
        .b_o(b), .d_o(d), .sh_o(sh), .rot_o(rot), .lsb_o(lsb), .w_o(w));
    pebf_unit i_pebf_unit (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .issue_i(iss), .op_i(op),
        .first_operand_i(a), .second_operand_i(b), .dest_old_i(d), .shift_amount_i(sh),
        .rotate_right_amount_i(rot), .field_lsb_i(lsb), .field_width_i(w), .result_o(res),
        .result_valid_o(rv), .flags_we_o(fw));
    // ****************
    // Reference and checks
    // ****************
    function automatic pebf_word_t ref_res(pebf_op_e o, pebf_word_t a, b, d, logic [4:0] s,
                                           logic [1:0] r, logic [4:0] l, logic [5:0] w);
        pebf_word_t x, m, q;
        q = (b >> (8 * r)) | (b << (32 - 8 * r));
        m = ((w == 6'h20) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1) << l;
        x = b << s;
        if (o == OP_PACK_LOW_THEN_HIGH) return {x[31:16], a[15:0]};
        // Cast keeps the shift signed inside the unsigned conditional
        x = (s == 5'h00) ? {32{b[31]}} : pebf_word_t'($signed(b) >>> s);
        if (o == OP_PACK_HIGH_THEN_LOW) return {a[31:16], x[15:0]};
        if (o == OP_FIELD_CLEAR) return d & ~m;
        if (o == OP_FIELD_INSERT) return (d & ~m) | ((a << l) & m);
        case (o)
            OP_SIGNED_BYTE_WIDEN, OP_SIGNED_BYTE_WIDEN_ADD: x = {{24{q[7]}}, q[7:0]};
            OP_UNSIGNED_BYTE_WIDEN, OP_UNSIGNED_BYTE_WIDEN_ADD: x = {24'h0, q[7:0]};
            OP_SIGNED_HALF_WIDEN, OP_SIGNED_HALF_WIDEN_ADD: x = {{16{q[15]}}, q[15:0]};
            OP_UNSIGNED_HALF_WIDEN, OP_UNSIGNED_HALF_WIDEN_ADD: x = {16'h0, q[15:0]};
            OP_DUAL_UNSIGNED_BYTE_WIDEN, OP_DUAL_UNSIGNED_BYTE_WIDEN_ADD: begin
                x = {8'h0, q[23:16], 8'h0, q[7:0]};
            end
            default: x = {{8{q[23]}}, q[23:16], {8{q[7]}}, q[7:0]};
        endcase
        if (o < OP_SIGNED_BYTE_WIDEN_ADD) return x;
        if (o > OP_UNSIGNED_HALF_WIDEN_ADD) return {a[31:16] + x[31:16], a[15:0] + x[15:0]};
        return a + x;
    endfunction
    task automatic check(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one operation and judge its write-back
    task automatic run(input pebf_op_e o, pebf_word_t a, b, d, logic [4:0] s,
                       logic [1:0] r, logic [4:0] l, logic [5:0] w);
        i_pebf_issuer.send(1'b1, o, a, b, d, s, r, l, w);
        #1;
        last = ref_res(o, a, b, d, s, r, l, w);
        check({31'h0, rv}, 32'h1);
        check(res, last);
        check({31'h0, fw}, 32'h0);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_pack;
        run(OP_PACK_LOW_THEN_HIGH, 32'h1234ABCD, 32'h8765F00F, 0, 5'h00, 0, 0, 1);
        run(OP_PACK_LOW_THEN_HIGH, 32'h1234ABCD, 32'h00000003, 0, 5'h1F, 0, 0, 1);
        run(OP_PACK_HIGH_THEN_LOW, 32'h1234ABCD, 32'h8765F00F, 0, 5'h00, 0, 0, 1);
        run(OP_PACK_HIGH_THEN_LOW, 32'h1234ABCD, 32'h4765F00F, 0, 5'h01, 0, 0, 1);
        run(OP_PACK_HIGH_THEN_LOW, 32'h1234ABCD, 32'h8765F00F, 0, 5'h14, 0, 0, 1);
        $display("pack test done");
    endtask
    task automatic t_widen;
        for (int r = 0; r < 4; r++) begin
            for (int k = 2; k < 14; k++) begin
                run(pebf_op_e'(16'h1 << k), 32'h0001FFFF, 32'h80FF7F81, 0, 0, 2'(r), 0,
                    1);
            end
        end
        run(OP_DUAL_SIGNED_BYTE_WIDEN_ADD, 32'h7FFFFFFF, 32'h00010001, 0, 0, 0, 0, 1);
        $display("widen test done");
    endtask
    task automatic t_field;
        run(OP_FIELD_CLEAR, 32'h0, 32'h0, 32'hFFFFFFFF, 0, 0, 5'h08, 6'h0C);
        run(OP_FIELD_CLEAR, 32'h0, 32'h0, 32'hFFFFFFFF, 0, 0, 5'h1F, 6'h01);
        run(OP_FIELD_INSERT, 32'hFFFFFABC, 32'h0, 32'h12345678, 0, 0, 5'h08, 6'h0C);
        run(OP_FIELD_INSERT, 32'hCAFE0123, 32'h0, 32'h12345678, 0, 0, 5'h00, 6'h20);
        $display("field test done");
    endtask
    // Illegal code and disabled issue leave result untouched
    task automatic t_refuse;
        i_pebf_issuer.send(1'b1, pebf_op_e'(16'h0003), 1, 1, 1, 0, 0, 0, 1);
        #1;
        check({31'h0, rv}, 32'h0);
        check(res, last);
        i_pebf_issuer.send(1'b0, OP_UNSIGNED_HALF_WIDEN, 1, 1, 1, 0, 0, 0, 1);
        #1;
        check({31'h0, rv}, 32'h0);
        check(res, last);
        $display("refuse test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
    initial begin
        srst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        #1;
        check({30'h0, fw, rv}, {30'h0, PEBF_FLAGS_RST, PEBF_VALID_RST});
        check(res, PEBF_RESULT_RST);
        t_pack();
        t_widen();
        t_field();
        t_refuse();
        end_of_test();
    end
endmodule
bind pebf_unit pebf_unit_props i_pebf_unit_props (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .issue_i(issue_i), .op_i(op_i), .first_operand_i(first_operand_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .flags_we_o(flags_we_o));
`default_nettype wire
